// *** verilog/utp_packetizer.sv ***
// Transparent UART packetizer with set/get parameter frames.
// Assumes bytes arrive as one-cycle strobes from a UART receiver.
`timescale 1ns/100ps
`default_nettype none

module utp_packetizer
  import utp_pkg::*;
#(
  parameter int CYC_PER_MS_P = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_restart,
  input wire logic [7:0] operating_mode_setting,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rts_n,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic pkt_valid,
  output logic [7:0] pkt_data,
  output logic pkt_last,
  input wire logic pkt_ready
);

  // ==========================================================
  // Declarations
  logic [7:0] sto_trig_q, sto_trig_d, sto_lim_q, sto_lim_d, sto_thr_q, sto_thr_d;
  logic [7:0] sto_mark_q, sto_mark_d, act_trig_q, act_trig_d, act_lim_q, act_lim_d;
  logic [7:0] act_thr_q, act_thr_d, act_mark_q, act_mark_d;
  logic [15:0] sto_idle_q, sto_idle_d, act_idle_q, act_idle_d;
  logic cmd_mode_q, cmd_mode_d, boot_q, boot_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [BUF_AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [7:0] pend_q, pend_d, left_q, left_d, mlen_q, mlen_d, occ, close_len, lim_eff;
  logic mark_q, mark_d, rts_n_q, rts_n_d;
  logic take, close, push, marker_mode, tmr_exp, fifo_in_ready;
  logic [FIFO_WIDTH-1:0] fifo_out;
  utp_parse_t pst_q, pst_d;
  logic [7:0] rcmd_q, rcmd_d, rlen_q, rlen_d, bidx_q, bidx_d, pos_q, pos_d, n_q, n_d;
  logic [7:0] xor_q, xor_d, status_q, status_d, txcs_q, txcs_d, tx_data_q, tx_data_d;
  logic [7:0] wbuf_q [WR_MAX];
  logic [7:0] wbuf_d [WR_MAX];
  logic [8:0] ridx_q, ridx_d;
  logic get_q, get_d, tx_valid_q, tx_valid_d, rx_cmd, tx_load, apply;
  logic [7:0] byte_out;

  // ==========================================================
  // Response encoding
  function automatic logic [7:0] setting_byte(input logic [7:0] pos);
    case (pos)
      POS_TRIG: setting_byte = sto_trig_q;
      POS_LIM: setting_byte = sto_lim_q;
      POS_THR: setting_byte = sto_thr_q;
      POS_MARK: setting_byte = sto_mark_q;
      POS_IDLE_LO: setting_byte = sto_idle_q[7:0];
      POS_IDLE_HI: setting_byte = sto_idle_q[15:8];
      default: setting_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [8:0] resp_last();
    resp_last = get_q ? RI_DATA + {1'b0, n_q} : RI_CNT;
  endfunction

  function automatic logic [7:0] resp_byte(input logic [8:0] idx);
    logic [8:0] off;
    off = idx - RI_DATA;
    if (idx == resp_last()) begin
      resp_byte = txcs_q;
    end else begin
      case (idx)
        RI_START: resp_byte = FR_START;
        RI_CMD: resp_byte = get_q ? RSP_GET : RSP_SET;
        RI_LEN: resp_byte = get_q ? 8'(n_q + GET_EXTRA) : SET_RSP_LEN;
        RI_ARG: resp_byte = get_q ? pos_q : status_q;
        RI_CNT: resp_byte = n_q;
        default: resp_byte = setting_byte(8'(pos_q + off[7:0]));
      endcase
    end
  endfunction

  // ==========================================================
  // Settings: stored copy and the copy in use
  always_comb begin
    sto_trig_d = sto_trig_q;
    sto_lim_d = sto_lim_q;
    sto_thr_d = sto_thr_q;
    sto_mark_d = sto_mark_q;
    sto_idle_d = sto_idle_q;
    if (apply) begin
      for (int i = 0; i < WR_MAX; i++) begin
        if (8'(i) < n_q) begin
          case (8'(pos_q + 8'(i)))
            POS_TRIG: sto_trig_d = wbuf_q[i];
            POS_LIM: sto_lim_d = wbuf_q[i];
            POS_THR: sto_thr_d = wbuf_q[i];
            POS_MARK: sto_mark_d = wbuf_q[i];
            POS_IDLE_LO: sto_idle_d[7:0] = wbuf_q[i];
            POS_IDLE_HI: sto_idle_d[15:8] = wbuf_q[i];
            default: ;
          endcase
        end
      end
    end
    // Writes never disturb a packet in flight
    act_trig_d = soft_restart ? sto_trig_q : act_trig_q;
    act_lim_d = soft_restart ? sto_lim_q : act_lim_q;
    act_thr_d = soft_restart ? sto_thr_q : act_thr_q;
    act_mark_d = soft_restart ? sto_mark_q : act_mark_q;
    act_idle_d = soft_restart ? sto_idle_q : act_idle_q;
    boot_d = 1'b0;
    // Mode level sampled after reset release, not under reset
    cmd_mode_d = (boot_q || soft_restart) ? (operating_mode_setting == OPERATING_MODE_SETTING_CMD) : cmd_mode_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sto_trig_q <= RST_TRIG;
      sto_lim_q <= RST_LIM;
      sto_thr_q <= RST_THR;
      sto_mark_q <= RST_MARK;
      sto_idle_q <= RST_IDLE;
      act_trig_q <= RST_TRIG;
      act_lim_q <= RST_LIM;
      act_thr_q <= RST_THR;
      act_mark_q <= RST_MARK;
      act_idle_q <= RST_IDLE;
      boot_q <= 1'b1;
      cmd_mode_q <= 1'b0;
    end else begin
      sto_trig_q <= sto_trig_d;
      sto_lim_q <= sto_lim_d;
      sto_thr_q <= sto_thr_d;
      sto_mark_q <= sto_mark_d;
      sto_idle_q <= sto_idle_d;
      act_trig_q <= act_trig_d;
      act_lim_q <= act_lim_d;
      act_thr_q <= act_thr_d;
      act_mark_q <= act_mark_d;
      act_idle_q <= act_idle_d;
      boot_q <= boot_d;
      cmd_mode_q <= cmd_mode_d;
    end
  end

  // ==========================================================
  // Transparent datapath: ring buffer, packet closing, flow control
  always_comb begin
    marker_mode = (act_trig_q == TRIG_MARKER);
    // An illegal limit of zero behaves as one
    lim_eff = (act_lim_q == 8'h00) ? 8'h01 : act_lim_q;
    occ = 8'(pend_q + left_q);
    // Bytes beyond a full buffer are lost; the pause request warns first
    take = rx_valid && !cmd_mode_q && (occ != BUF_FULL);
    push = (left_q != 8'h00) && fifo_in_ready;
    close = 1'b0;
    close_len = pend_q;
    if (!cmd_mode_q && left_q == 8'h00 && pend_q != 8'h00) begin
      if (marker_mode && mark_q && mlen_q <= lim_eff) begin
        close = 1'b1;
        close_len = mlen_q;
      end else if (pend_q >= lim_eff) begin
        close = 1'b1;
        close_len = lim_eff;
      end else if (!marker_mode && tmr_exp) begin
        close = 1'b1;
      end
    end
    pend_d = 8'(pend_q - (close ? close_len : 8'h00) + {7'h00, take});
    left_d = close ? close_len : 8'(left_q - {7'h00, push});
    wp_d = take ? wp_q + 1'b1 : wp_q;
    rp_d = push ? rp_q + 1'b1 : rp_q;
    mark_d = mark_q;
    mlen_d = mlen_q;
    if (close && mark_q) begin
      mark_d = close_len < mlen_q;
      mlen_d = 8'(mlen_q - close_len);
    end
    // A marker arriving with a closure still sets the flag
    if (take && marker_mode && rx_data == act_mark_q && !mark_d) begin
      mark_d = 1'b1;
      mlen_d = pend_d;
    end
    rts_n_d = !cmd_mode_q && (occ >= act_thr_q);
    if (soft_restart) begin
      pend_d = 8'h00;
      left_d = 8'h00;
      // Stale ring bytes would leak into the next packet
      wp_d = '0;
      rp_d = '0;
      mark_d = 1'b0;
      rts_n_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= '0;
      rp_q <= '0;
      pend_q <= 8'h00;
      left_q <= 8'h00;
      mlen_q <= 8'h00;
      mark_q <= 1'b0;
      rts_n_q <= 1'b0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      pend_q <= pend_d;
      left_q <= left_d;
      mlen_q <= mlen_d;
      mark_q <= mark_d;
      rts_n_q <= rts_n_d;
    end
  end

  always_ff @(posedge clk) begin
    if (take) begin
      buf_q[wp_q] <= rx_data;
    end
  end

  utp_idle_timer #(
    .CYC_MS(CYC_PER_MS_P)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .restart(take),
    .arm(!cmd_mode_q && !marker_mode && pend_q != 8'h00),
    .delay_ms(act_idle_q),
    .expired(tmr_exp)
  );

  utp_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(left_q != 8'h00),
    .in_ready(fifo_in_ready),
    .in_data({left_q == 8'h01, buf_q[rp_q]}),
    .out_valid(pkt_valid),
    .out_ready(pkt_ready),
    .out_data(fifo_out)
  );

  // ==========================================================
  // Command frames: parser and responder
  always_comb begin
    rx_cmd = rx_valid && cmd_mode_q;
    tx_load = (pst_q == P_RESP) && (!tx_valid_q || tx_ready);
    byte_out = resp_byte(ridx_q);
    apply = 1'b0;
    pst_d = pst_q;
    rcmd_d = rcmd_q;
    rlen_d = rlen_q;
    bidx_d = bidx_q;
    pos_d = pos_q;
    n_d = n_q;
    xor_d = xor_q;
    status_d = status_q;
    get_d = get_q;
    ridx_d = ridx_q;
    txcs_d = txcs_q;
    wbuf_d = wbuf_q;
    tx_data_d = tx_data_q;
    tx_valid_d = tx_valid_q && !tx_ready;
    case (pst_q)
      P_START: if (rx_cmd && rx_data == FR_START) begin
        xor_d = rx_data;
        pst_d = P_CMD;
      end
      P_CMD: if (rx_cmd) begin
        rcmd_d = rx_data;
        xor_d = xor_q ^ rx_data;
        pst_d = P_LEN;
      end
      P_LEN: if (rx_cmd) begin
        rlen_d = rx_data;
        xor_d = xor_q ^ rx_data;
        bidx_d = 8'h00;
        pst_d = (rx_data == 8'h00) ? P_SUM : P_BODY;
      end
      P_BODY: if (rx_cmd) begin
        xor_d = xor_q ^ rx_data;
        if (bidx_q == BODY_POS) begin
          pos_d = rx_data;
        end else if (bidx_q == BODY_CNT) begin
          n_d = rx_data;
        end else if (8'(bidx_q - BODY_DATA) < 8'(WR_MAX)) begin
          wbuf_d[2'(bidx_q - BODY_DATA)] = rx_data;
        end
        bidx_d = 8'(bidx_q + 8'h01);
        if (bidx_q == 8'(rlen_q - 8'h01)) begin
          pst_d = P_SUM;
        end
      end
      P_SUM: if (rx_cmd) begin
        ridx_d = RI_START;
        txcs_d = 8'h00;
        if (rcmd_q == CMD_SET) begin
          apply = (rx_data == xor_q);
          status_d = apply ? ST_OK : ST_FAIL;
          get_d = 1'b0;
          pst_d = P_RESP;
        end else if (rcmd_q == CMD_GET && rx_data == xor_q) begin
          get_d = 1'b1;
          pst_d = P_RESP;
        end else begin
          pst_d = P_START;
        end
      end
      P_RESP: if (tx_load) begin
        tx_data_d = byte_out;
        tx_valid_d = 1'b1;
        txcs_d = txcs_q ^ byte_out;
        ridx_d = ridx_q + 9'h001;
        if (ridx_q == resp_last()) begin
          pst_d = P_START;
        end
      end
      default: pst_d = P_START;
    endcase
    if (soft_restart) begin
      pst_d = P_START;
      tx_valid_d = 1'b0;
      apply = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pst_q <= P_START;
      rcmd_q <= 8'h00;
      rlen_q <= 8'h00;
      bidx_q <= 8'h00;
      pos_q <= 8'h00;
      n_q <= 8'h00;
      xor_q <= 8'h00;
      status_q <= ST_OK;
      get_q <= 1'b0;
      ridx_q <= RI_START;
      txcs_q <= 8'h00;
      wbuf_q <= '{default: 8'h00};
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
    end else begin
      pst_q <= pst_d;
      rcmd_q <= rcmd_d;
      rlen_q <= rlen_d;
      bidx_q <= bidx_d;
      pos_q <= pos_d;
      n_q <= n_d;
      xor_q <= xor_d;
      status_q <= status_d;
      get_q <= get_d;
      ridx_q <= ridx_d;
      txcs_q <= txcs_d;
      wbuf_q <= wbuf_d;
      tx_data_q <= tx_data_d;
      tx_valid_q <= tx_valid_d;
    end
  end

  assign rts_n = rts_n_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign pkt_data = fifo_out[7:0];
  assign pkt_last = fifo_out[8];

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_set_load(logic [8:0] k);
    tx_load && !get_q && !soft_restart && ridx_q == k;
  endsequence

  trig_mode_gate_a: assert property (close |-> !cmd_mode_q)
    else $error("packet closed in command operation");
  frame_len_end_a: assert property (pst_q == P_BODY && rx_cmd && !soft_restart &&
      bidx_q == 8'(rlen_q - 8'h01) |=> pst_q == P_SUM)
    else $error("frame end not taken from length");
  idle_close_a: assert property (!cmd_mode_q && !marker_mode && tmr_exp &&
      left_q == 8'h00 && pend_q != 8'h00 && pend_q < lim_eff
      |-> close && close_len == pend_q)
    else $error("idle expiry did not close packet");
  marker_flag_a: assert property (take && marker_mode && rx_data == act_mark_q &&
      !soft_restart |=> mark_q)
    else $error("end marker not caught");
  limit_close_a: assert property (!cmd_mode_q && left_q == 8'h00 && pend_q >= lim_eff &&
      !(marker_mode && mark_q) |-> close && close_len == lim_eff)
    else $error("length limit did not close packet");
  flow_pause_a: assert property (!cmd_mode_q && occ >= act_thr_q && !soft_restart
      |=> rts_n)
    else $error("pause request missing at threshold");
  marker_mode_a: assert property (mark_q |-> marker_mode && !cmd_mode_q)
    else $error("marker flag outside trigger mode 1");
  idle_restart_a: assert property (take |=> !tmr_exp)
    else $error("idle timer not restarted by byte");
  ack_cmd_byte_a: assert property (s_set_load(RI_CMD) |=> tx_valid && tx_data == RSP_SET)
    else $error("write acknowledge code wrong");
  ack_sum_byte_a: assert property (s_set_load(RI_CNT) ##0 status_q == ST_OK
      |=> tx_data == (FR_START ^ RSP_SET ^ SET_RSP_LEN ^ ST_OK))
    else $error("write acknowledge checksum wrong");
  read_len_byte_a: assert property (tx_load && get_q && ridx_q == RI_LEN
      |=> tx_data == 8'($past(n_q) + GET_EXTRA))
    else $error("read answer length wrong");
  limit_write_a: assert property (apply && pos_q == POS_LIM && n_q != 8'h00
      |=> sto_lim_q == $past(wbuf_q[0]))
    else $error("length limit position not written");
  idle_lsb_first_a: assert property (apply && pos_q == POS_IDLE_LO && n_q == 8'h02
      |=> sto_idle_q == {$past(wbuf_q[1]), $past(wbuf_q[0])})
    else $error("idle delay byte order wrong");
  restart_only_a: assert property ($changed(act_lim_q) || $changed(act_idle_q)
      |-> $past(soft_restart))
    else $error("setting in use changed without restart");
  bad_sum_drop_a: assert property (pst_q == P_SUM && rx_cmd && rcmd_q == CMD_GET &&
      rx_data != xor_q && !soft_restart |=> pst_q == P_START)
    else $error("read with bad checksum answered");

endmodule // utp_packetizer

`default_nettype wire

// *** verilog/utp_pkg.sv ***
// Constants, frame codes and types shared by the packetizer files.
// Assumes a 10 MHz system clock and a host UART that hands over whole bytes.
`default_nettype none

package utp_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  // Whole cycles per millisecond
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // ==========================================================
  // Buffering
  localparam int BUF_DEPTH = 128;
  localparam int BUF_AW = $clog2(BUF_DEPTH);
  localparam logic [7:0] BUF_FULL = 8'h80;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 9;
  localparam int WR_MAX = 4;

  // ==========================================================
  // Setting positions and reset values
  localparam logic [7:0] POS_TRIG = 8'h05;
  localparam logic [7:0] POS_LIM = 8'h07;
  localparam logic [7:0] POS_THR = 8'h08;
  localparam logic [7:0] POS_MARK = 8'h09;
  localparam logic [7:0] POS_IDLE_LO = 8'h0c;
  localparam logic [7:0] POS_IDLE_HI = 8'h0d;
  localparam logic [7:0] RST_TRIG = 8'h00;
  localparam logic [7:0] RST_LIM = 8'h80;
  localparam logic [7:0] RST_THR = 8'h70;
  localparam logic [7:0] RST_MARK = 8'h0a;
  localparam logic [15:0] RST_IDLE = 16'h0005;
  localparam logic [7:0] TRIG_MARKER = 8'h01;
  localparam logic [7:0] OPERATING_MODE_SETTING_CMD = 8'h10;

  // ==========================================================
  // Frame codes and positions inside a frame
  localparam logic [7:0] FR_START = 8'h02;
  localparam logic [7:0] CMD_SET = 8'h09;
  localparam logic [7:0] CMD_GET = 8'h0a;
  localparam logic [7:0] RSP_SET = 8'h49;
  localparam logic [7:0] RSP_GET = 8'h4a;
  localparam logic [7:0] SET_RSP_LEN = 8'h01;
  localparam logic [7:0] GET_EXTRA = 8'h02;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_FAIL = 8'h01;
  localparam logic [7:0] BODY_POS = 8'h00;
  localparam logic [7:0] BODY_CNT = 8'h01;
  localparam logic [7:0] BODY_DATA = 8'h02;
  localparam logic [8:0] RI_START = 9'h000;
  localparam logic [8:0] RI_CMD = 9'h001;
  localparam logic [8:0] RI_LEN = 9'h002;
  localparam logic [8:0] RI_ARG = 9'h003;
  localparam logic [8:0] RI_CNT = 9'h004;
  localparam logic [8:0] RI_DATA = 9'h005;

  typedef enum logic [2:0] {P_START, P_CMD, P_LEN, P_BODY, P_SUM, P_RESP} utp_parse_t;

endpackage

`default_nettype wire

// *** verilog/utp_fifo.sv ***
// Small FIFO with a registered head, valid and ready on both sides.
// Assumes DEPTH is a power of two and one clock for both sides.
`timescale 1ns/100ps
`default_nettype none

module utp_fifo
  import utp_pkg::*;
#(
  parameter int WIDTH = FIFO_WIDTH,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic ov_q, ov_d;
  logic [WIDTH-1:0] od_q, od_d;
  logic push, pop;

  // ==========================================================
  // Pointers and head register
  always_comb begin
    push = in_valid && (cnt_q != FULL);
    // Head refills as soon as it is empty or being taken
    pop = (cnt_q != '0) && (!ov_q || out_ready);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    ov_d = pop ? 1'b1 : (out_ready ? 1'b0 : ov_q);
    od_d = pop ? mem_q[rd_q] : od_q;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  assign in_ready = (cnt_q != FULL);
  assign out_valid = ov_q;
  assign out_data = od_q;

endmodule // utp_fifo

`default_nettype wire

// *** verilog/utp_idle_timer.sv ***
// Millisecond idle timer, restarted by every received byte.
// Assumes CYC_MS of at least two cycles.
`timescale 1ns/100ps
`default_nettype none

module utp_idle_timer
  import utp_pkg::*;
#(
  parameter int CYC_MS = CYC_PER_MS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic arm,
  input wire logic [15:0] delay_ms,
  output logic expired
);

  localparam int CW = $clog2(CYC_MS);
  localparam logic [CW-1:0] CYC_LAST = CW'(CYC_MS - 1);

  logic [CW-1:0] cyc_q, cyc_d;
  logic [15:0] ms_q, ms_d;
  logic exp_q, exp_d;

  // ==========================================================
  // Count whole milliseconds since the last byte
  always_comb begin
    cyc_d = cyc_q;
    ms_d = ms_q;
    exp_d = exp_q;
    if (restart || !arm) begin
      cyc_d = '0;
      ms_d = '0;
      exp_d = 1'b0;
    end else if (!exp_q) begin
      if (cyc_q == CYC_LAST) begin
        cyc_d = '0;
        ms_d = ms_q + 16'h0001;
        exp_d = (ms_q + 16'h0001) >= delay_ms;
      end else begin
        cyc_d = cyc_q + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_q <= '0;
      ms_q <= '0;
      exp_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      ms_q <= ms_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;

endmodule // utp_idle_timer

`default_nettype wire

// *** verif/utp_host_model.sv ***
// Host side of the response path: takes reply bytes with stalls.
// Assumes the bench reads the collected bytes from rsp.
`timescale 1ns/100ps
`default_nettype none
module utp_host_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rsp[$];
  logic [1:0] cnt_q;
  // ==========
  // Slow host: ready half the time, so replies must hold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 2'h0;
    else cnt_q <= cnt_q + 2'h1;
  end
  assign tx_ready = cnt_q[1];
  always @(posedge clk) if (tx_valid && tx_ready) rsp.push_back(tx_data);
endmodule // utp_host_model
`default_nettype wire

// *** verif/utp_packetizer_tb_top.sv ***
// Bench: setting frames, then limit and marker packets.
// Assumes utp_pkg and the host model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module utp_packetizer_tb_top;
  import utp_pkg::*;
  logic clk, rst_n, soft_restart, rx_valid, pkt_ready, rts_n, tx_valid, tx_ready;
  logic pkt_valid, pkt_last;
  logic [7:0] operating_mode_setting, rx_data, tx_data, pkt_data;
  logic [16:0] lf, lr;
  logic [8:0] want[$];
  int failures, cmp_count;
  utp_packetizer #(.CYC_PER_MS_P(4)) u_utp_packetizer (.clk(clk), .rst_n(rst_n),
    .soft_restart(soft_restart), .operating_mode_setting(operating_mode_setting),
    .rx_valid(rx_valid), .rx_data(rx_data), .rts_n(rts_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .pkt_valid(pkt_valid), .pkt_data(pkt_data),
    .pkt_last(pkt_last), .pkt_ready(pkt_ready));
  utp_host_model u_utp_host_model (.clk(clk), .rst_n(rst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  // ==========
  // Helpers
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic results();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic abort_run();
    failures++;
    results();
  endtask
  task automatic chk(input string n, input logic [8:0] e, input logic [8:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic send(input logic [7:0] b);
    int k;
    for (k = 0; k < 300 && rts_n !== 1'b0; k++) tick();
    if (k == 300) abort_run();
    rx_valid = 1'b1;
    rx_data = b;
    tick();
  endtask
  // Sends a frame plus checksum, then compares the whole reply
  task automatic frame(input logic [7:0] f[$], input logic [7:0] r[$]);
    logic [7:0] c;
    int k;
    c = 8'h00;
    foreach (f[i]) c ^= f[i];
    f.push_back(c);
    c = 8'h00;
    foreach (r[i]) c ^= r[i];
    r.push_back(c);
    foreach (f[i]) send(f[i]);
    rx_valid = 1'b0;
    for (k = 0; k < 300 && u_utp_host_model.rsp.size() < r.size(); k++) tick();
    if (k == 300) abort_run();
    foreach (r[i]) chk("tx_data", {1'b0, r[i]}, {1'b0, u_utp_host_model.rsp.pop_front()});
    tick();
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    frame('{FR_START, CMD_SET, 8'h03, p, 8'h01, v}, '{FR_START, RSP_SET, SET_RSP_LEN, ST_OK});
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] v);
    frame('{FR_START, CMD_GET, 8'h02, p, 8'h01}, '{FR_START, RSP_GET, 8'h03, p, 8'h01, v});
  endtask
  task automatic restart(input logic [7:0] m);
    operating_mode_setting = m;
    soft_restart = 1'b1;
    tick();
    soft_restart = 1'b0;
    tick();
  endtask
  // Limit is 3 here; byte 1 is always the marker value
  task automatic burst(input int n, input logic t, input logic r);
    logic [7:0] b;
    int c, k;
    c = 0;
    for (int i = 0; i < n; i++) begin
      lf = nx(lf);
      b = (i == 1) ? RST_MARK : (lf[7:0] | 8'h80);
      c++;
      want.push_back({(c == 3) || (t && i == 1) || (i == n - 1), b});
      if (want[$][8]) c = 0;
      send(b);
    end
    rx_valid = 1'b0;
    tick();
    chk("rts_n", {8'h00, r}, {8'h00, rts_n});
    for (k = 0; k < 400 && want.size() > 0; k++) tick();
    if (k == 400) abort_run();
    chk("pkt_left", 9'h000, 9'(want.size()));
    chk("rts_low", 9'h000, {8'h00, rts_n});
  endtask
  // ==========
  // Radio side: random stalls, every byte checked
  always @(posedge clk) begin
    if (pkt_valid === 1'b1 && pkt_ready === 1'b1) begin
      if (want.size() == 0) chk("pkt_extra", 9'h000, 9'h001);
      else chk("pkt", want.pop_front(), {pkt_last, pkt_data});
    end
    #1;
    lr = nx(lr);
    pkt_ready = lr[0] | lr[1];
  end
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    soft_restart = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    pkt_ready = 1'b0;
    operating_mode_setting = OPERATING_MODE_SETTING_CMD;
    failures = 0;
    cmp_count = 0;
    lf = 17'd71190;
    lr = 17'd71190;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    tick();
    tick();
    rd(POS_TRIG, RST_TRIG);
    rd(POS_THR, RST_THR);
    rd(POS_MARK, RST_MARK);
    frame('{FR_START, CMD_GET, 8'h02, POS_IDLE_LO, 8'h02},
      '{FR_START, RSP_GET, 8'h04, POS_IDLE_LO, 8'h02, 8'h05, 8'h00});
    wr(POS_LIM, 8'h03);
    // Wrong checksum byte 0x0a: refused write, trailing byte ignored
    frame('{FR_START, CMD_SET, 8'h03, POS_LIM, 8'h01, 8'h05, 8'h0a},
      '{FR_START, RSP_SET, SET_RSP_LEN, ST_FAIL});
    rd(POS_LIM, 8'h03);
    restart(8'h00);
    burst(7, 1'b0, 1'b0);
    restart(OPERATING_MODE_SETTING_CMD);
    wr(POS_TRIG, TRIG_MARKER);
    restart(8'h00);
    burst(5, 1'b1, 1'b0);
    restart(OPERATING_MODE_SETTING_CMD);
    wr(POS_THR, 8'h02);
    restart(8'h00);
    // Two bytes reach a threshold of 2: pause request rises, then falls
    burst(2, 1'b1, 1'b1);
    results();
  end
endmodule // utp_packetizer_tb_top
`default_nettype wire
